// *** verilog/spi_port_defs.svh ***
// offsets, field positions, reset values and widths of the serial register port
`ifndef SPI_PORT_DEFS_SVH
`define SPI_PORT_DEFS_SVH

`define SP_FRAME_BITS 40
`define SP_LAST_BIT 6'h27
`define SP_CNT_DONE 6'h28
`define SP_RW_BIT 39
`define SP_DATA_BITS 32

`define SP_ADDR_MODE 7'h00
`define SP_ADDR_LUT_WR 7'h60
`define SP_ADDR_LUT_RD 7'h61
`define SP_ADDR_IRQ_MASK 7'h62
`define SP_ADDR_IRQ_STATUS 7'h63
`define SP_ADDR_VERSION 7'h7f

`define SP_MODE_RESET 10'h002
`define SP_MASK_RESET 8'h00
`define SP_LUT_WR_ADDR_LSB 16
`define SP_LUT_WR_ADDR_MSB 28
`define SP_LUT_RD_ADDR_MSB 12
`define SP_LUT_DATA_MSB 11
`define SP_LUT_DEPTH 8192
`define SP_LUT_WIDTH 12
`define SP_LUT_ABITS 13

`endif

// *** verilog/spi_port_pkg.sv ***
// types shared by the serial register port
package spi_port_pkg;
   typedef logic [9:0] mode_t;
   typedef logic [7:0] irq_t;
   typedef struct packed {
      logic rw;
      logic [6:0] addr;
      logic [31:0] data;
   } frame_t;
endpackage

// *** verilog/lut_ram.sv ***
// single port waveform memory, synchronous write and registered read
`timescale 1ns/10ps
module lut_ram #(
   parameter int DEPTH = 8192,
   parameter int WIDTH = 12,
   parameter int ABITS = 13
) (
   input wire logic clock,
   input wire logic we,
   input wire logic [ABITS-1:0] addr,
   input wire logic [WIDTH-1:0] wrData,
   output logic [WIDTH-1:0] rdData
);
   logic [WIDTH-1:0] mem [DEPTH];

   // contents are undefined after power-up; software must fill the table
   always_ff @(posedge clock) begin
      if (we) begin
         mem[addr] <= wrData;
      end
      rdData <= mem[addr];
   end
endmodule

// *** verilog/spi_register_port.sv ***
// serial register port with waveform memory access and interrupt output
//
// Overview of operation
// - every transfer is a 40-bit frame: address byte then four data bytes
// - each register moves as a full 32-bit data field
// - top bit of the address byte: 0 reads, 1 writes the register
// - registers are write-only, read/write or read-only
// - waveform memory holds 8192 words of 12 bits
// - one address writes memory entries, another reads them back
// - memory read data comes back in the following frame
// - a read-only register returns a fixed type and revision code
// - unmasked pending condition pulls the open-drain interrupt pin low
// - read/write flag is bit 39, shifted first, most significant first
// - values are right aligned; unused upper bits read zero
`timescale 1ns/10ps
`include "spi_port_defs.svh"
module spi_register_port #(
   parameter logic [31:0] VERSION_ID = 32'h00a5c001, // arbitrary value
   parameter int IRQ_N = 8
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic csn,
   input wire logic sdi,
   output logic sdo,
   output logic sdoOe,
   input wire logic [IRQ_N-1:0] irqCond,
   output spi_port_pkg::mode_t modeOut,
   output logic irqOutLow,
   output logic irqOutLowOe
);
   import spi_port_pkg::*;

   // link domain (sclk, mode 3)
   logic linkClr;
   logic [5:0] bitCnt_reg;
   logic [5:0] bitCnt_next;
   logic [38:0] rxShift_reg;
   logic [39:0] frameWord_reg;
   logic frameTgl_reg;
   logic [38:0] txShift_reg;
   logic sdo_reg;
   logic sdoOe_reg;
   logic frameLast;

   // chip select high clears the frame state; no sclk edge is needed
   assign linkClr = csn | ~rst_n;
   assign frameLast = (bitCnt_reg == `SP_LAST_BIT);
   // count saturates, so surplus bits after the 40th never re-commit
   assign bitCnt_next = (bitCnt_reg == `SP_CNT_DONE) ? bitCnt_reg
                        : bitCnt_reg + 6'h1;

   always_ff @(posedge sclk or posedge linkClr) begin
      if (linkClr) begin
         bitCnt_reg <= 6'h0;
         rxShift_reg <= '0;
      end else begin
         bitCnt_reg <= bitCnt_next;
         rxShift_reg <= {rxShift_reg[37:0], sdi};
      end
   end

   // the 40th rising edge completes the frame; shorter frames die with csn
   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         frameWord_reg <= '0;
         frameTgl_reg <= 1'h0;
      end else if (frameLast) begin
         frameWord_reg <= {rxShift_reg, sdi};
         frameTgl_reg <= ~frameTgl_reg;
      end
   end

   logic [39:0] txWord_reg;

   // reply word is loaded at the first falling edge; the system side only
   // changes it between frames, which makes it a quasi-static crossing
   always_ff @(negedge sclk or posedge linkClr) begin
      if (linkClr) begin
         txShift_reg <= '0;
         sdo_reg <= 1'h0;
         sdoOe_reg <= 1'h0;
      end else begin
         sdoOe_reg <= 1'h1;
         if (bitCnt_reg == 6'h0) begin
            sdo_reg <= txWord_reg[`SP_RW_BIT];
            txShift_reg <= txWord_reg[38:0];
         end else begin
            sdo_reg <= txShift_reg[38];
            txShift_reg <= {txShift_reg[37:0], 1'h0};
         end
      end
   end

   assign sdo = sdo_reg;
   assign sdoOe = sdoOe_reg;

   // system domain
   logic frameSync1_reg;
   logic frameSync2_reg;
   logic frameSeen_reg;
   logic newFrame;
   frame_t frame;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         frameSync1_reg <= 1'h0;
         frameSync2_reg <= 1'h0;
         frameSeen_reg <= 1'h0;
      end else begin
         frameSync1_reg <= frameTgl_reg;
         frameSync2_reg <= frameSync1_reg;
         frameSeen_reg <= frameSync2_reg;
      end
   end

   // frame word is stable from its toggle until the next frame's last bit
   assign newFrame = frameSync2_reg ^ frameSeen_reg;
   assign frame = frame_t'(frameWord_reg);

   function automatic logic hit(input logic [6:0] a, input logic [6:0] t);
      hit = (a == t);
   endfunction

   logic isWrite;
   logic isRead;
   logic wrMode;
   logic wrMask;
   logic wrLut;
   logic rdLut;
   logic rdStatus;

   assign isWrite = newFrame & frame.rw;
   assign isRead = newFrame & ~frame.rw;
   assign wrMode = isWrite & hit(frame.addr, `SP_ADDR_MODE);
   assign wrMask = isWrite & hit(frame.addr, `SP_ADDR_IRQ_MASK);
   assign wrLut = isWrite & hit(frame.addr, `SP_ADDR_LUT_WR);
   assign rdLut = isRead & hit(frame.addr, `SP_ADDR_LUT_RD);
   assign rdStatus = isRead & hit(frame.addr, `SP_ADDR_IRQ_STATUS);

   // waveform memory
   logic ramWe;
   logic [`SP_LUT_ABITS-1:0] ramAddr;
   logic [`SP_LUT_WIDTH-1:0] ramWrData;
   logic [`SP_LUT_WIDTH-1:0] ramRdData;

   assign ramWe = wrLut;
   assign ramAddr = wrLut
      ? frame.data[`SP_LUT_WR_ADDR_MSB:`SP_LUT_WR_ADDR_LSB]
      : frame.data[`SP_LUT_RD_ADDR_MSB:0];
   assign ramWrData = frame.data[`SP_LUT_DATA_MSB:0];

   lut_ram #(
      .DEPTH(`SP_LUT_DEPTH),
      .WIDTH(`SP_LUT_WIDTH),
      .ABITS(`SP_LUT_ABITS)
   ) u_lut (
      .clock(clock),
      .we(ramWe),
      .addr(ramAddr),
      .wrData(ramWrData),
      .rdData(ramRdData)
   );

   // registers
   mode_t mode_reg;
   irq_t mask_reg;
   logic [IRQ_N-1:0] status_reg;
   logic [IRQ_N-1:0] status_next;
   logic [IRQ_N-1:0] statusClr;
   logic lutPending_reg;
   logic irqOe_reg;
   logic irqActive;
   logic [7:0] statusByte;
   logic [31:0] readMux;
   logic [39:0] txWord_next;

   // status is clear-on-read; a condition in the same cycle still sets
   assign statusClr = rdStatus ? '1 : '0;
   assign status_next = (status_reg & ~statusClr) | irqCond;
   assign irqActive = |(status_reg & IRQ_N'(mask_reg));
   assign statusByte = 8'(status_reg);

   // read-only and read/write registers; write-only ones answer zero
   assign readMux =
      hit(frame.addr, `SP_ADDR_MODE) ? {22'h0, mode_reg} :
      hit(frame.addr, `SP_ADDR_IRQ_MASK) ? {24'h0, mask_reg} :
      hit(frame.addr, `SP_ADDR_IRQ_STATUS) ? {24'h0, statusByte} :
      hit(frame.addr, `SP_ADDR_VERSION) ? VERSION_ID :
      32'h0;

   // address slot of a reply carries the pending condition flags
   assign txWord_next =
      (isRead & ~rdLut) ? {statusByte, readMux} :
      lutPending_reg ? {statusByte, 20'h0, ramRdData} :
      txWord_reg;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg <= `SP_MODE_RESET;
         mask_reg <= `SP_MASK_RESET;
         status_reg <= '0;
         lutPending_reg <= 1'h0;
         txWord_reg <= '0;
         irqOe_reg <= 1'h0;
      end else begin
         if (wrMode) begin
            mode_reg <= frame.data[9:0];
         end
         if (wrMask) begin
            mask_reg <= frame.data[7:0];
         end
         status_reg <= status_next;
         lutPending_reg <= rdLut;
         txWord_reg <= txWord_next;
         irqOe_reg <= irqActive;
      end
   end

   assign modeOut = mode_reg;
   // open-drain: the pin only ever drives low, enable decides
   assign irqOutLow = 1'h0 & irqOe_reg;
   assign irqOutLowOe = irqOe_reg;

   // assertions
   sequence lutReq;
      newFrame && !frame.rw && frame.addr == `SP_ADDR_LUT_RD;
   endsequence

   sequence modeWrite;
      newFrame && frame.rw && frame.addr == `SP_ADDR_MODE;
   endsequence

   a_frame_commit: assert property (
      @(posedge sclk) disable iff (!rst_n)
      $changed(frameTgl_reg) |-> $past(bitCnt_reg) == `SP_LAST_BIT)
      else $error("frame committed before 40 bits");

   a_mode_write: assert property (
      @(posedge clock) disable iff (!rst_n)
      modeWrite |=> mode_reg == $past(frame.data[9:0]))
      else $error("mode register not written");

   a_read_nowrite: assert property (
      @(posedge clock) disable iff (!rst_n)
      (newFrame && !frame.rw) |=> $stable(mode_reg) && $stable(mask_reg))
      else $error("read frame changed a register");

   a_version_read: assert property (
      @(posedge clock) disable iff (!rst_n)
      (isRead && frame.addr == `SP_ADDR_VERSION)
      |=> txWord_reg[31:0] == VERSION_ID)
      else $error("type code not returned");

   a_lut_return: assert property (
      @(posedge clock) disable iff (!rst_n)
      lutReq |-> ##2 (txWord_reg[11:0] == $past(ramRdData)
                      && txWord_reg[31:12] == 20'h0))
      else $error("memory read data not returned");

   a_lut_write: assert property (
      @(posedge clock) disable iff (!rst_n)
      (isWrite && frame.addr == `SP_ADDR_LUT_WR) |->
      ramWe && ramAddr == frame.data[28:16])
      else $error("memory write not issued");

   a_mode_align: assert property (
      @(posedge clock) disable iff (!rst_n)
      (isRead && frame.addr == `SP_ADDR_MODE)
      |=> txWord_reg[31:10] == 22'h0 && txWord_reg[9:0] == $past(mode_reg))
      else $error("mode not right aligned");

   a_irq_drive: assert property (
      @(posedge clock) disable iff (!rst_n)
      irqActive |=> irqOutLowOe)
      else $error("interrupt pin not pulled low");

   a_irq_masked: assert property (
      @(posedge clock) disable iff (!rst_n)
      !irqActive |=> !irqOutLowOe)
      else $error("masked interrupt drives pin");

   a_status_sticky: assert property (
      @(posedge clock) disable iff (!rst_n)
      (irqCond != '0) |=> (status_reg & $past(irqCond)) == $past(irqCond))
      else $error("condition lost from status");
endmodule

// *** tb/spi_host_model.sv ***
// host side serial bus master model for the register port
`timescale 1ns/10ps
module spi_host_model (
   output logic sclk,
   output logic csn,
   output logic sdi,
   input wire logic sdo,
   input wire logic sdoOe
);
   initial begin
      sclk = 1'h1;
      csn = 1'h1;
      sdi = 1'h0;
   end
   // mode 3, 160 ns link period; the clock stands high between frames
   task automatic xfer(input logic [39:0] tx, input int nbits,
      output logic [39:0] rx);
      rx = '0;
      csn = 1'h0;
      #37;
      for (int i = 0; i < nbits; i++) begin
         sclk = 1'h0;
         sdi = tx[39-i];
         #80;
         sclk = 1'h1;
         // an undriven line must never read as a valid bit
         rx[39-i] = sdoOe ? sdo : 1'hx;
         #80;
      end
      csn = 1'h1;
      sdi = ~sdi;
      // gap above 400 ns lets the reply word settle
      #600;
   endtask
endmodule

// *** tb/spi_register_port_with_lut_ram_test.sv ***
// self-checking bench for the serial register port
`timescale 1ns/10ps
module spi_register_port_with_lut_ram_test;
   import spi_port_pkg::*;
   localparam logic [31:0] TEST_ID = 32'h5eed0c0d; // arbitrary value
   logic clock, rst_n, sclk, csn, sdi, sdo, sdoOe, irqOutLow, irqOutLowOe;
   logic [7:0] irqCond;
   mode_t modeOut;
   logic [39:0] rx;
   int errCount, checkCount, cycles;
   // open-drain pin with pull-up
   wire irqPin = irqOutLowOe ? irqOutLow : 1'h1;

   spi_register_port #(.VERSION_ID(TEST_ID), .IRQ_N(8)) u_spi_register_port (
      .clock(clock), .rst_n(rst_n), .sclk(sclk), .csn(csn), .sdi(sdi),
      .sdo(sdo), .sdoOe(sdoOe), .irqCond(irqCond), .modeOut(modeOut),
      .irqOutLow(irqOutLow), .irqOutLowOe(irqOutLowOe));
   spi_host_model u_spi_host_model (.sclk(sclk), .csn(csn), .sdi(sdi),
      .sdo(sdo), .sdoOe(sdoOe));

   initial begin
      clock = 1'h0;
      forever #25 clock = ~clock;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp,
      input string what);
      checkCount++;
      if (got !== exp) begin
         errCount++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      u_spi_host_model.xfer({1'h1, a, d}, 40, rx);
   endtask
   // the reply comes one frame late, so a second read collects it
   task automatic rd(input logic [6:0] a);
      u_spi_host_model.xfer({1'h0, a, 32'h0}, 40, rx);
      u_spi_host_model.xfer({1'h0, 7'h00, 32'h0}, 40, rx);
   endtask
   task automatic pulse(input logic [7:0] c);
      @(posedge clock);
      irqCond <= c;
      @(posedge clock);
      irqCond <= 8'h00;
      repeat (3) @(posedge clock);
   endtask

   task automatic testReset;
      check({22'h0, modeOut}, 32'h002, "mode reset");
      check({31'h0, irqPin}, 32'h1, "irq idle");
      check({31'h0, sdoOe}, 32'h0, "sdo idle");
   endtask
   task automatic testMode;
      wr(7'h00, 32'hfffffda5);
      check({22'h0, modeOut}, 32'h1a5, "mode write");
      check({31'h0, sdoOe}, 32'h0, "sdo released");
      rd(7'h00);
      check(rx[31:0], 32'h1a5, "mode read");
      rd(7'h60);
      check(rx[31:0], 32'h0, "write-only read");
   endtask
   task automatic testShort;
      u_spi_host_model.xfer({1'h1, 7'h00, 32'h0ff}, 39, rx);
      check({22'h0, modeOut}, 32'h1a5, "short frame");
   endtask
   task automatic testVersion;
      wr(7'h7f, 32'h0);
      rd(7'h7f);
      check(rx[31:0], TEST_ID, "version");
   endtask
   task automatic testLut;
      // entries are loaded before any of them is read back
      wr(7'h60, {3'h0, 13'h1fff, 4'h0, 12'habc});
      wr(7'h60, {3'h0, 13'h0000, 4'h0, 12'h123});
      u_spi_host_model.xfer({1'h0, 7'h61, 32'h1fff}, 40, rx);
      u_spi_host_model.xfer({1'h0, 7'h61, 32'h0}, 40, rx);
      check(rx[31:0], 32'habc, "lut top");
      u_spi_host_model.xfer({1'h0, 7'h00, 32'h0}, 40, rx);
      check(rx[31:0], 32'h123, "lut bottom");
   endtask
   task automatic testIrq;
      wr(7'h62, 32'h04);
      pulse(8'h01);
      check({31'h0, irqPin}, 32'h1, "masked irq");
      pulse(8'h04);
      check({31'h0, irqPin}, 32'h0, "unmasked irq");
      check({31'h0, irqOutLow}, 32'h0, "pin level");
      rd(7'h63);
      check(rx[31:0], 32'h05, "status read");
      check({24'h0, rx[39:32]}, 32'h05, "status slot");
      check({31'h0, irqPin}, 32'h1, "irq cleared");
   endtask

   task automatic testDone;
      $display("checks %0d errors %0d", checkCount, errCount);
      if (errCount == 0 && checkCount > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 10000) begin
         errCount++;
         $display("ERROR %0t timeout", $time);
         testDone;
      end
   end

   initial begin
      rst_n = 1'h0;
      irqCond = 8'h00;
      repeat (5) @(posedge clock);
      rst_n <= 1'h1;
      repeat (2) @(posedge clock);
      testReset;
      testMode;
      testShort;
      testVersion;
      testLut;
      testIrq;
      testDone;
   end
endmodule
